// File: pkg/slr_pkg.sv
// Purpose: Shared constants and types for the link release and status register bank.
// Assumes: Eight-bit registers reached through a plain address/strobe port.
// Notes:   Offsets are the printed register addresses.
package slr_pkg;
    localparam int          ADDR_W          = 10;
    localparam int          DATA_W          = 8;
    localparam logic [9:0]  OFF_RELEASE     = 10'h106;
    localparam logic [9:0]  OFF_STATUS      = 10'h107;
    localparam logic [9:0]  OFF_PLL_REF_DIVISOR      = 10'h108;
    localparam logic [9:0]  OFF_CONTROL     = 10'h110;
    localparam logic [9:0]  OFF_IRQ_MASK    = 10'h111;
    localparam logic [9:0]  OFF_KM1         = 10'h112;
    localparam logic [7:0]  RELEASE_RESET   = 8'h00;
    localparam logic [7:0]  PLL_REF_DIVISOR_RESET    = 8'h30;
    localparam logic [7:0]  KM1_RESET       = 8'h1F;
    localparam logic [7:0]  FIELD6_MASK     = 8'h3F;
    localparam int          BIT_SLIP        = 7;
    localparam int          BIT_LINK        = 6;
    localparam int          BIT_SYNC        = 5;
    localparam int          BIT_RESYNC      = 4;
    localparam int          BIT_CONSIST     = 3;
    localparam int          BIT_LOCK        = 2;
    localparam int          CTL_ENABLE      = 0;
    localparam int          CTL_SUBCLASS    = 1;
    localparam int          CTL_ENCODING    = 2;
    localparam int          OCTETS_PER_STEP = 4;
    localparam int          MF_W            = 10;
    localparam int          MB_STEPS        = 64;
    localparam logic [2:0]  MAX_SYSREF      = 3'h7;
    localparam logic [7:0]  STATUS_W1C      = 8'h90;
    typedef enum logic [1:0] {
        SLR_IDLE,
        SLR_WAIT,
        SLR_UP
    } slr_link_t;
endpackage : slr_pkg

// File: pkg/slr_if.sv
// Purpose: Register port between the controlling party and the device.
// Assumes: One clock; read data valid the cycle after the read strobe.
// Notes:   Device modport answers, host modport drives.
`timescale 1ns/10ps
`default_nettype none
interface slr_if;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    modport device (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : slr_if
`default_nettype wire

// File: logic/slr_pll_ref_divisor.sv
// Purpose: Divides the converter clock by the programmed divisor.
// Assumes: Divisor is one of the legal even or small values.
// Notes:   Output high for the first div_i/2 cycles of each period, rounded down.
`timescale 1ns/10ps
`default_nettype none
module slr_pll_ref_divisor (
    // Clock and reset.
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // Divisor.
    input  wire logic [5:0] div_i,
    // Reference out.
    output var  logic       ref_o
);
    import slr_pkg::*;
    logic [5:0] count;
    always_ff @(posedge clock_i) begin
        if (reset_i || count + 6'h01 >= div_i) begin
            count <= 6'h00;
        end else begin
            count <= count + 6'h01;
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ref_o <= 1'b0;
        end else begin
            ref_o <= (count < (div_i >> 1));
        end
    end
endmodule : slr_pll_ref_divisor
`default_nettype wire

// File: logic/slr_device.sv
// Purpose: Device end: release delay, reference divisor and link status registers.
// Assumes: Lane, buffer and alignment events arrive as pins from the link logic.
// Notes:   Pins are synchronised by two flip-flops before use.
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module slr_device (
    // Clock and reset.
    input  wire logic  clock_i,
    input  wire logic  reset_i,
    // Register port.
    slr_if.device      bus,
    // Link pins.
    input  wire logic  lanes_writing_i,
    input  wire logic  buffer_fault_i,
    input  wire logic  sync_line_state_i,
    input  wire logic  sysref_i,
    input  wire logic  sysref_match_i,
    input  wire logic  pll_locked_i,
    // Outputs.
    output var  logic  release_o,
    output var  logic  link_enable_o,
    output var  logic  line_encoding_select_o,
    output var  logic  pll_ref_clk_o,
    output var  logic  irq_o
);
    import slr_pkg::*;
    logic [7:0]      release_delay;
    logic [7:0]      pll_reference_divisor;
    logic [7:0]      control;
    logic [7:0]      irq_mask;
    logic [7:0]      frames_per_multiframe_minus1;
    logic [7:0]      link_status;
    logic [7:0]      next_rdata;
    logic [5:0]      meta;
    logic [5:0]      pins;
    logic            sysref_prev;
    logic            sysref_edge;
    logic [MF_W-1:0] mf_count;
    logic [MF_W-1:0] mf_length;
    logic [MF_W-1:0] release_point;
    logic            buffer_slip_flag;
    logic            resync_flag;
    logic            sysref_consistent_flag;
    logic            ref_clk;
    slr_link_t       state;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
        hit = (a == off);
    endfunction : hit

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            meta <= 6'h00;
            pins <= 6'h00;
        end else begin
            meta <= {lanes_writing_i, buffer_fault_i, sync_line_state_i, sysref_i, sysref_match_i, pll_locked_i};
            pins <= meta;
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sysref_prev <= 1'b0;
        end else begin
            sysref_prev <= pins[2];
        end
    end
    assign sysref_edge = pins[2] & ~sysref_prev;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            release_delay                <= RELEASE_RESET;
            pll_reference_divisor        <= PLL_REF_DIVISOR_RESET;
            control                      <= 8'h00;
            irq_mask                     <= 8'h00;
            frames_per_multiframe_minus1 <= KM1_RESET;
        end else if (bus.wr) begin
            if (hit(bus.addr, OFF_RELEASE)) release_delay <= bus.wdata & FIELD6_MASK;
            if (hit(bus.addr, OFF_PLL_REF_DIVISOR)) pll_reference_divisor <= bus.wdata & FIELD6_MASK;
            if (hit(bus.addr, OFF_CONTROL)) control <= bus.wdata;
            if (hit(bus.addr, OFF_IRQ_MASK)) irq_mask <= bus.wdata;
            if (hit(bus.addr, OFF_KM1)) frames_per_multiframe_minus1 <= bus.wdata;
        end
    end

    // Multiframe length in 4-octet steps: K (8b/10b) or fixed 64 steps (64b/66b).
    assign mf_length = control[CTL_ENCODING] ? MF_W'(MB_STEPS)
                                             : MF_W'(frames_per_multiframe_minus1) + MF_W'(1);
    assign release_point = MF_W'(release_delay[5:0]);

    always_ff @(posedge clock_i) begin
        if (reset_i || !control[CTL_ENABLE] || (sysref_edge && control[CTL_SUBCLASS])) begin
            mf_count <= '0;
        end else if (mf_count + MF_W'(1) >= mf_length) begin
            mf_count <= '0;
        end else begin
            mf_count <= mf_count + MF_W'(1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i || !control[CTL_ENABLE]) begin
            state <= SLR_IDLE;
        end else begin
            unique case (state)
                SLR_IDLE: if (pins[5]) state <= SLR_WAIT;
                SLR_WAIT: begin
                    if (!control[CTL_SUBCLASS] || mf_count == release_point) state <= SLR_UP;
                end
                SLR_UP: if (!pins[5]) state <= SLR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i || !control[CTL_ENABLE]) begin
            sysref_consistent_flag <= 1'b0;
        end else if (sysref_edge) begin
            sysref_consistent_flag <= pins[1];
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            buffer_slip_flag <= 1'b0;
        end else if (pins[4] && state == SLR_UP) begin
            buffer_slip_flag <= 1'b1;
        end else if (bus.wr && hit(bus.addr, OFF_STATUS) && bus.wdata[BIT_SLIP]) begin
            buffer_slip_flag <= 1'b0;
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            resync_flag <= 1'b0;
        end else if (sysref_edge && control[CTL_SUBCLASS] && mf_count != '0) begin
            resync_flag <= 1'b1;
        end else if (bus.wr && hit(bus.addr, OFF_STATUS) && bus.wdata[BIT_RESYNC]) begin
            resync_flag <= 1'b0;
        end
    end

    always_comb begin
        link_status              = 8'h00;
        link_status[BIT_SLIP]    = buffer_slip_flag;
        link_status[BIT_LINK]    = (state == SLR_UP);
        link_status[BIT_SYNC]    = pins[3];
        link_status[BIT_RESYNC]  = resync_flag;
        link_status[BIT_CONSIST] = sysref_consistent_flag;
        link_status[BIT_LOCK]    = pins[0];
    end

    always_comb begin
        next_rdata = 8'h00;
        if (hit(bus.addr, OFF_RELEASE)) next_rdata = release_delay;
        if (hit(bus.addr, OFF_STATUS)) next_rdata = link_status;
        if (hit(bus.addr, OFF_PLL_REF_DIVISOR)) next_rdata = pll_reference_divisor;
        if (hit(bus.addr, OFF_CONTROL)) next_rdata = control;
        if (hit(bus.addr, OFF_IRQ_MASK)) next_rdata = irq_mask;
        if (hit(bus.addr, OFF_KM1)) next_rdata = frames_per_multiframe_minus1;
    end
    always_ff @(posedge clock_i) begin
        if (reset_i || !bus.rd) begin
            bus.rdata <= 8'h00;
        end else begin
            bus.rdata <= next_rdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            release_o              <= 1'b0;
            link_enable_o          <= 1'b0;
            line_encoding_select_o <= 1'b0;
            irq_o                  <= 1'b0;
            pll_ref_clk_o          <= 1'b0;
        end else begin
            release_o              <= (state == SLR_UP);
            link_enable_o          <= control[CTL_ENABLE];
            line_encoding_select_o <= control[CTL_ENCODING];
            irq_o                  <= |(link_status & STATUS_W1C & irq_mask);
            pll_ref_clk_o          <= ref_clk;
        end
    end

    slr_pll_ref_divisor slr_pll_ref_divisor_inst (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .div_i   (pll_reference_divisor[5:0]),
        .ref_o   (ref_clk)
    );
endmodule : slr_device
`default_nettype wire

// File: logic/slr_host.sv
// Purpose: Controlling end: turns user requests into register port cycles.
// Assumes: Device answers read data one cycle after the read strobe.
// Notes:   Refuses illegal delay, divisor, and delay writes while enabled.
`timescale 1ns/10ps
`default_nettype none
module slr_host (
    // Clock and reset.
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // User side.
    input  wire logic       req_wr_i,
    input  wire logic       req_rd_i,
    input  wire logic [9:0] req_addr_i,
    input  wire logic [7:0] req_wdata_i,
    output var  logic [7:0] rsp_data_o,
    output var  logic       rsp_valid_o,
    output var  logic       refused_o,
    // Register port.
    slr_if.host             bus
);
    import slr_pkg::*;
    logic       enabled;
    logic       encoding;
    logic [7:0] km1;
    logic       pending;
    logic       allowed;
    logic [10:0] limit;

    function automatic logic legal_div(input logic [7:0] d);
        unique case (d)
            8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h0C,
            8'h10, 8'h14, 8'h18, 8'h20, 8'h28, 8'h30: legal_div = 1'b1;
            default: legal_div = 1'b0;
        endcase
    endfunction : legal_div

    // Delay limit with F taken as one octet: K/4-1 steps; 63 steps with 64b/66b.
    assign limit = encoding ? 11'h03F : 11'((11'(km1) + 11'h001) >> 2) - 11'h001;
    always_comb begin
        allowed = 1'b1;
        if (req_addr_i == OFF_RELEASE) begin
            allowed = !enabled && (11'(req_wdata_i) <= limit);
        end
        if (req_addr_i == OFF_PLL_REF_DIVISOR) allowed = legal_div(req_wdata_i);
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            enabled  <= 1'b0;
            encoding <= 1'b0;
            km1      <= KM1_RESET;
        end else if (req_wr_i && allowed) begin
            if (req_addr_i == OFF_CONTROL) begin
                enabled  <= req_wdata_i[CTL_ENABLE];
                encoding <= req_wdata_i[CTL_ENCODING];
            end
            if (req_addr_i == OFF_KM1) km1 <= req_wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            bus.addr    <= 10'h000;
            bus.wdata   <= 8'h00;
            bus.wr      <= 1'b0;
            bus.rd      <= 1'b0;
            pending     <= 1'b0;
            rsp_data_o  <= 8'h00;
            rsp_valid_o <= 1'b0;
            refused_o   <= 1'b0;
        end else begin
            bus.addr    <= req_addr_i;
            bus.wdata   <= req_wdata_i;
            bus.wr      <= req_wr_i && allowed;
            bus.rd      <= req_rd_i && !req_wr_i;
            refused_o   <= req_wr_i && !allowed;
            pending     <= bus.rd;
            rsp_valid_o <= pending;
            rsp_data_o  <= pending ? bus.rdata : rsp_data_o;
        end
    end
endmodule : slr_host
`default_nettype wire

// File: testbench/slr_properties.sv
// Purpose: Checker for the register port between the host and device ends.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Sees only the interface signals.
`timescale 1ns/10ps
`default_nettype none
module slr_properties
    import slr_pkg::*;
(
    // Clock and reset.
    input wire logic       clock_i,
    input wire logic       reset_i,
    // Register port.
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata
);
    logic enabled;

    // Tracks the link enable bit as written over the port.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            enabled <= 1'b0;
        end else if (wr && addr == OFF_CONTROL) begin
            enabled <= wdata[CTL_ENABLE];
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    a_single_strobe: assert property (!(wr && rd))
        else $error("Read and write strobes high together");
    a_idle_rdata: assert property (!rd |=> rdata == 8'h00)
        else $error("Read data without a read");
    a_reserved_low: assert property (
        rd && addr == OFF_STATUS |=> rdata[1:0] == 2'h0)
        else $error("Reserved status bits not zero");
    a_delay_range: assert property (
        wr && addr == OFF_RELEASE |-> wdata <= 8'h3F)
        else $error("Release delay write out of range");
    a_delay_guard: assert property (
        wr && addr == OFF_RELEASE |-> !enabled)
        else $error("Release delay written while enabled");
    a_divisor_legal: assert property (
        wr && addr == OFF_PLL_REF_DIVISOR |-> wdata inside {8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0A,
                                                   8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h28, 8'h30})
        else $error("Illegal divisor written");
    a_delay_readback: assert property (
        wr && addr == OFF_RELEASE ##1 rd && addr == OFF_RELEASE |=> rdata == $past(wdata, 2))
        else $error("Release delay read back wrong");
    a_divisor_readback: assert property (
        wr && addr == OFF_PLL_REF_DIVISOR ##1 rd && addr == OFF_PLL_REF_DIVISOR |=> rdata == $past(wdata, 2))
        else $error("Divisor read back wrong");
    a_flags_hold: assert property (
        rd && addr == OFF_STATUS ##1 rd && addr == OFF_STATUS |=> ($past(rdata) & STATUS_W1C & ~rdata) == 8'h00)
        else $error("Event flag dropped without a write");
endmodule : slr_properties
`default_nettype wire

// File: testbench/serial_link_release_status_regs_bench.sv
// Purpose: Self-checking bench for the host and device ends joined by the register port.
// Assumes: 200 MHz clock, synchronous active-high reset held 16 cycles.
// Notes:   Expected answers wait in a queue until the host reports them.
`timescale 1ns/10ps
`default_nettype none
module serial_link_release_status_regs_bench;
    import slr_pkg::*;
    logic        clock_i;
    logic        reset_i;
    logic        req_wr_i;
    logic        req_rd_i;
    logic [9:0]  req_addr_i;
    logic [7:0]  req_wdata_i;
    logic [7:0]  rsp_data_o;
    logic        rsp_valid_o;
    logic        refused_o;
    logic        lanes_writing_i;
    logic        buffer_fault_i;
    logic        sync_line_state_i;
    logic        sysref_i;
    logic        sysref_match_i;
    logic        pll_locked_i;
    logic        release_o;
    logic        link_enable_o;
    logic        line_encoding_select_o;
    logic        pll_ref_clk_o;
    logic        irq_o;
    logic [16:0] notes[$];
    logic [16:0] note;
    logic [15:0] seed;
    logic        prev;
    int          fails;
    int          tests_run;
    int          cycles;
    int          rises;
    logic [7:0]  legal[14] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h10, 8'h14, 8'h18,
                               8'h20, 8'h28, 8'h30};

    slr_if link ();
    slr_host slr_host_inst (.clock_i(clock_i), .reset_i(reset_i), .req_wr_i(req_wr_i), .req_rd_i(req_rd_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .rsp_data_o(rsp_data_o),
        .rsp_valid_o(rsp_valid_o), .refused_o(refused_o), .bus(link));
    slr_device slr_device_inst (.clock_i(clock_i), .reset_i(reset_i), .bus(link),
        .lanes_writing_i(lanes_writing_i), .buffer_fault_i(buffer_fault_i), .sync_line_state_i(sync_line_state_i),
        .sysref_i(sysref_i), .sysref_match_i(sysref_match_i), .pll_locked_i(pll_locked_i), .release_o(release_o),
        .link_enable_o(link_enable_o), .line_encoding_select_o(line_encoding_select_o),
        .pll_ref_clk_o(pll_ref_clk_o), .irq_o(irq_o));
    slr_properties slr_properties_inst (.clock_i(clock_i), .reset_i(reset_i), .addr(link.addr),
        .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic op(input logic w, input logic [9:0] a, input logic [7:0] d);
        req_wr_i    <= w;
        req_rd_i    <= !w;
        req_addr_i  <= a;
        req_wdata_i <= d;
        @(posedge clock_i);
    endtask : op

    task automatic idle(input int n);
        req_wr_i <= 1'b0;
        req_rd_i <= 1'b0;
        repeat (n) @(posedge clock_i);
    endtask : idle

    // A refused write waits for earlier answers so the notes stay in order.
    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic refuse);
        if (refuse) begin
            idle(5);
            notes.push_back({1'b1, 16'h0000});
        end
        op(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [7:0] v, input logic [7:0] m);
        notes.push_back({1'b0, m, v});
        op(1'b0, a, 8'h00);
    endtask : rd

    task automatic pulse_fault();
        buffer_fault_i <= 1'b1;
        idle(2);
        buffer_fault_i <= 1'b0;
        idle(6);
    endtask : pulse_fault

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // Compares each answer with the oldest note and cuts a hang short.
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            results();
        end
        if (rsp_valid_o === 1'b1 || refused_o === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected answer", 9'h000, 9'h1FF);
            end else begin
                note = notes.pop_front();
                check("answer", {refused_o, rsp_data_o & note[15:8]}, {note[16], note[7:0] & note[15:8]});
            end
        end
    end

    initial begin
        reset_i <= 1'b1;
        req_wr_i <= 1'b0;
        req_rd_i <= 1'b0;
        req_addr_i <= 10'h000;
        req_wdata_i <= 8'h00;
        lanes_writing_i <= 1'b0;
        buffer_fault_i <= 1'b0;
        sync_line_state_i <= 1'b1;
        sysref_i <= 1'b0;
        sysref_match_i <= 1'b0;
        pll_locked_i <= 1'b1;
        seed = 16'h2EAE;
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        rd(OFF_RELEASE, RELEASE_RESET, 8'hFF);
        rd(OFF_PLL_REF_DIVISOR, PLL_REF_DIVISOR_RESET, 8'hFF);
        rd(OFF_KM1, KM1_RESET, 8'hFF);
        rd(OFF_STATUS, 8'h24, 8'hFF);
        wr(10'h1FF, seed[7:0], 1'b0);
        rd(10'h1FF, 8'h00, 8'hFF);
        sync_line_state_i <= 1'b0;
        pll_locked_i <= 1'b0;
        idle(6);
        rd(OFF_STATUS, 8'h00, 8'h24);
        sync_line_state_i <= 1'b1;
        pll_locked_i <= 1'b1;
        $display("done: reset values and status pins");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(OFF_RELEASE, {5'h00, seed[2:0]}, 1'b0);
            rd(OFF_RELEASE, {5'h00, seed[2:0]}, 8'hFF);
        end
        wr(OFF_RELEASE, 8'h08, 1'b1);
        wr(OFF_CONTROL, 8'h04, 1'b0);
        idle(6);
        check("encoding", line_encoding_select_o, 1'b1);
        wr(OFF_RELEASE, 8'h3F, 1'b0);
        rd(OFF_RELEASE, 8'h3F, 8'hFF);
        wr(OFF_RELEASE, 8'h40, 1'b1);
        wr(OFF_CONTROL, 8'h00, 1'b0);
        wr(OFF_RELEASE, 8'h05, 1'b0);
        $display("done: release delay");
        foreach (legal[i]) begin
            wr(OFF_PLL_REF_DIVISOR, legal[i], 1'b0);
            rd(OFF_PLL_REF_DIVISOR, legal[i], 8'hFF);
            idle(8);
            if (48 % legal[i] == 0) begin
                rises = 0;
                repeat (48) begin
                    prev = pll_ref_clk_o;
                    @(posedge clock_i);
                    rises += int'(prev === 1'b0 && pll_ref_clk_o === 1'b1);
                end
                check("reference rises", rises[8:0], 9'(48 / legal[i]));
            end
        end
        wr(OFF_PLL_REF_DIVISOR, 8'h07, 1'b1);
        $display("done: reference divisor");
        wr(OFF_CONTROL, 8'h01, 1'b0);
        lanes_writing_i <= 1'b1;
        idle(10);
        check("link up", {link_enable_o, release_o}, 2'h3);
        rd(OFF_STATUS, 8'h40, 8'h40);
        wr(OFF_RELEASE, 8'h01, 1'b1);
        wr(OFF_IRQ_MASK, 8'h90, 1'b0);
        pulse_fault();
        check("irq raised", irq_o, 1'b1);
        rd(OFF_STATUS, 8'h80, 8'h80);
        rd(OFF_STATUS, 8'h80, 8'h80);
        wr(OFF_STATUS, 8'h80, 1'b0);
        idle(6);
        check("irq cleared", irq_o, 1'b0);
        rd(OFF_STATUS, 8'h00, 8'h80);
        wr(OFF_IRQ_MASK, 8'h00, 1'b0);
        pulse_fault();
        check("irq masked", irq_o, 1'b0);
        wr(OFF_STATUS, 8'h80, 1'b0);
        $display("done: slip flag and interrupt");
        wr(OFF_CONTROL, 8'h03, 1'b0);
        sysref_match_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i == 7) begin
                sysref_match_i <= 1'b0;
                rd(OFF_STATUS, 8'h18, 8'h18);
                wr(OFF_STATUS, 8'h08, 1'b0);
                rd(OFF_STATUS, 8'h18, 8'h18);
                wr(OFF_STATUS, 8'h10, 1'b0);
                rd(OFF_STATUS, 8'h08, 8'h18);
                check("subclass one release", release_o, 1'b1);
            end
            idle(34);
            sysref_i <= 1'b1;
            idle(3);
            sysref_i <= 1'b0;
        end
        idle(8);
        rd(OFF_STATUS, 8'h00, 8'h08);
        wr(OFF_CONTROL, 8'h00, 1'b0);
        idle(6);
        check("release dropped", release_o, 1'b0);
        wr(OFF_CONTROL, 8'h03, 1'b0);
        idle(5);
        check("release held for delay", release_o, 1'b0);
        idle(10);
        check("release at delay point", release_o, 1'b1);
        idle(8);
        $display("done: sysref alignment");
        results();
    end
endmodule : serial_link_release_status_regs_bench
`default_nettype wire
